// ### logic/sss_pkg.sv
/*
 Constants of the steering setting supervisor: register map, field
 positions, reset values, level tables and timing counts.
 Assumes a 40 MHz clock and an APB master for all software access.
*/
// How it works
// - Compensation level 0 none, 1 switches, 2 winding
// - Hold time: 0 none, 1 6s, 9 90s
// - Released and idle: ramp hold torque to zero
// - Hold torque is percent of maximum current
// - First direction clamp +80, +84, +3.8 steps
// - Second direction clamp -80, -84 to -118
// - Both coarse limits at 9 inhibit limiting
// - Feedback above mid uses first limits, below second
// - Closed loop: coarse setting scales set-point gain
// - Closed loop: fine settings add to gain
// - Centre sensitivity cut up to 4.5 times
// - Integral weight filters feedback position only
// - Derivative weight acts on feedback position only
// - Current command kept within maximum current
// - Fieldbus absent: no alarm, no start sync
// - Fine conversion on at 1, off otherwise
// - Closed loop: pot jump over slope raises fault
// - Slope limit 61 plus 18 per level, 410 top
// - Slope level resets to 9
package sss_pkg;
	localparam int CLK_PERIOD_NS    = 25;
	localparam int MS_NS            = 1000000;
	localparam int MS_CYCLES        = MS_NS / CLK_PERIOD_NS;
	localparam int SLOPE_WIN_MS     = 16;
	localparam int SLOPE_WIN_CYCLES = SLOPE_WIN_MS * MS_CYCLES;
	localparam int HOLD_L1_MS       = 6000;
	localparam int HOLD_L9_MS       = 90000;
	localparam int HOLD_STEP_MS     = (HOLD_L9_MS - HOLD_L1_MS) / 8;
	localparam int RAMP_LOG2        = 8;

	localparam logic [11:0] CFG_ADDR  = 12'h000;
	localparam logic [11:0] LIM_ADDR  = 12'h004;
	localparam logic [11:0] CUR_ADDR  = 12'h008;
	localparam logic [11:0] STAT_ADDR = 12'h00C;
	localparam logic [31:0] CFG_RST   = 32'h0000_0000;
	localparam logic [31:0] LIM_RST   = 32'h0000_0000;
	localparam logic [31:0] CUR_RST   = 32'h0009_0FFF;

	localparam int COMP_LSB  = 0;
	localparam int HOLDT_LSB = 4;
	localparam int HOLDQ_LSB = 8;
	localparam int LOOP_BIT  = 16;
	localparam int BUSP_BIT  = 17;
	localparam int FINE_LSB  = 20;
	localparam int RES_LSB   = 24;
	localparam int C1_LSB    = 0;
	localparam int C2_LSB    = 4;
	localparam int F1_LSB    = 8;
	localparam int F2_LSB    = 12;
	localparam int NUMB_LSB  = 16;
	localparam int IW_LSB    = 20;
	localparam int DW_LSB    = 24;
	localparam int MAXI_LSB  = 0;
	localparam int SLOPE_LSB = 16;

	localparam logic [3:0]  LEVEL_MAX   = 4'h9;
	localparam logic [6:0]  PCT_MAX     = 7'h64;
	localparam int          SLOPE_BASE  = 61;
	localparam int          SLOPE_STEP  = 18;
	localparam int          SLOPE_TOP   = 410;
	localparam int          ANG_L0      = 800;
	localparam int          ANG_L1      = 840;
	localparam int          ANG_STEP    = 38;
	localparam int          ANG_L9      = 1180;
	localparam logic [11:0] FB_MID      = 12'h800;
	localparam logic [15:0] SWITCH_DROP = 16'h0040;
	localparam int          NUMB_FULL   = 64;
	localparam int          NUMB_SPAN   = 50;
	localparam int          GAIN_BASE   = 64;
	localparam int          COARSE_STEP = 8;

	typedef enum logic [2:0] {
		HOLD_IDLE = 3'h1,
		HOLD_RAMP = 3'h2,
		HOLD_DONE = 3'h4
	} sss_hold_t;
endpackage : sss_pkg

// ### logic/sss_top.sv
/*
 Steering setting supervisor: APB settings registers, drop compensation,
 standstill hold ramp, angle limits, closed-loop gain shaping, current
 ceiling, fieldbus gating, fine conversion select and pot slope monitor.
 Assumes ADC samples and angle come from logic on clk; pins are raw.
*/
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
module sss_top
	import sss_pkg::*;
#(
	parameter int MS_CYCLES_P    = MS_CYCLES,
	parameter int SLOPE_CYCLES_P = SLOPE_WIN_CYCLES
)
(
	input  wire logic               clk,                 // 40 MHz clock
	input  wire logic               srst,                // Sync reset
	input  wire logic [11:0]        paddr,               // APB address
	input  wire logic               psel,                // APB select
	input  wire logic               penable,             // APB enable
	input  wire logic               pwrite,              // APB direction
	input  wire logic [31:0]        pwdata,              // APB write data
	output logic      [31:0]        prdata,              // APB read data
	output logic                    pready,              // APB ready
	output logic                    pslverr,             // APB error
	input  wire logic               handle_released,     // Pin, async
	input  wire logic               travel_demand,       // Pin, async
	input  wire logic               fieldbus_timeout,    // Pin, async
	input  wire logic [11:0]        command_pot_a,       // First pot
	input  wire logic [11:0]        command_pot_b,       // Second pot
	input  wire logic [11:0]        feedback_position_reading, // Feedback
	input  wire logic signed [11:0] wheel_angle,         // Tenths deg
	input  wire logic [11:0]        motor_current_meas,  // Measured
	output logic signed [12:0]      motor_current_cmd,   // Loop output
	output logic      [11:0]        hold_current,        // Standstill
	output logic      [15:0]        drop_comp,           // Volt offset
	output logic signed [11:0]      wheel_angle_limited, // Clamped
	output logic                    first_limit_hit,     // Clamp +
	output logic                    second_limit_hit,    // Clamp -
	output logic                    fine_adc_en,         // Fine ADC
	output logic                    fieldbus_fault_alarm, // Bus alarm
	output logic                    fieldbus_sync_en,    // Start sync
	output logic                    setpoint_sensor_fault // Latched
);

	typedef struct packed {
		logic [31:0]        cfg;
		logic [31:0]        lim;
		logic [31:0]        cur;
		logic [31:0]        rdata;
		logic [2:0]         sync1;
		logic [2:0]         sync2;
		logic [31:0]        ms_cnt;
		logic [31:0]        win_cnt;
		logic [11:0]        prev_a;
		logic [11:0]        prev_b;
		logic               prev_ok;
		logic               fault;
		sss_hold_t          hold;
		logic [7:0]         frac;
		logic [31:0]        hcnt;
		logic [11:0]        hold_cur;
		logic signed [12:0] fb_filt;
		logic signed [12:0] fb_prev;
		logic signed [12:0] cmd;
		logic signed [11:0] ang;
		logic               hit1;
		logic               hit2;
		logic [15:0]        comp;
		logic               fine_en;
		logic               bus_alarm;
	} sss_state_t;

	sss_state_t st, n;

	function automatic logic [3:0] sat9(input logic [3:0] v);
		sat9 = (v > LEVEL_MAX) ? LEVEL_MAX : v;
	endfunction : sat9

	function automatic int ang_lim(input logic [3:0] l);
		if (l == 4'h0)
			ang_lim = ANG_L0;
		else if (l == LEVEL_MAX)
			ang_lim = ANG_L9;
		else
			ang_lim = ANG_L1 + (int'(l) - 1) * ANG_STEP;
	endfunction : ang_lim

	// ************************************************************
	// Settings fields
	// ************************************************************
	logic [1:0]  comp_level, fine_sel;
	logic [3:0]  hold_time_level, first_dir_limit_coarse;
	logic [3:0]  second_dir_limit_coarse, first_dir_limit_fine;
	logic [3:0]  second_dir_limit_fine, numb_level, integral_weight;
	logic [3:0]  derivative_weight, setpoint_slope_limit;
	logic [6:0]  hold_torque_level;
	logic        closed_loop, bus_present;
	logic [11:0] max_current;

	assign comp_level              = st.cfg[COMP_LSB +: 2];
	assign hold_time_level         = sat9(st.cfg[HOLDT_LSB +: 4]);
	assign hold_torque_level       = st.cfg[HOLDQ_LSB +: 7];
	assign closed_loop             = st.cfg[LOOP_BIT];
	assign bus_present             = st.cfg[BUSP_BIT];
	assign fine_sel                = st.cfg[FINE_LSB +: 2];
	assign first_dir_limit_coarse  = sat9(st.lim[C1_LSB +: 4]);
	assign second_dir_limit_coarse = sat9(st.lim[C2_LSB +: 4]);
	assign first_dir_limit_fine    = sat9(st.lim[F1_LSB +: 4]);
	assign second_dir_limit_fine   = sat9(st.lim[F2_LSB +: 4]);
	assign numb_level              = sat9(st.lim[NUMB_LSB +: 4]);
	assign integral_weight         = sat9(st.lim[IW_LSB +: 4]);
	assign derivative_weight       = sat9(st.lim[DW_LSB +: 4]);
	assign max_current             = st.cur[MAXI_LSB +: 12];
	assign setpoint_slope_limit    = sat9(st.cur[SLOPE_LSB +: 4]);

	logic        rel, trv, bto, hit, tick, wtick, inhibit, fb_high;
	logic [31:0] status;

	assign rel     = st.sync2[0];
	assign trv     = st.sync2[1];
	assign bto     = st.sync2[2];
	assign hit     = (paddr == CFG_ADDR) || (paddr == LIM_ADDR) ||
		(paddr == CUR_ADDR) || (paddr == STAT_ADDR);
	assign tick    = st.ms_cnt == 32'(MS_CYCLES_P - 1);
	assign wtick   = st.win_cnt == 32'(SLOPE_CYCLES_P - 1);
	assign inhibit = (first_dir_limit_coarse == LEVEL_MAX) &&
		(second_dir_limit_coarse == LEVEL_MAX);
	assign fb_high = feedback_position_reading > FB_MID;
	assign status  = {26'h0, st.bus_alarm, st.fine_en, st.hit2, st.hit1,
		st.hold == HOLD_RAMP, st.fault};

	// Working values, all set at the top of the process below
	int     lim1, lim2, slope_lim, da, db, hold_ms, start_cur;
	int     sp, mag, centre, g, dg, fb, deriv, e;
	longint per_cyc;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		n         = st;
		lim1      = ang_lim(first_dir_limit_coarse);
		lim2      = ang_lim(second_dir_limit_coarse);
		slope_lim = (setpoint_slope_limit == LEVEL_MAX) ? SLOPE_TOP :
			SLOPE_BASE + int'(setpoint_slope_limit) * SLOPE_STEP;
		da        = int'(command_pot_a) - int'(st.prev_a);
		db        = int'(command_pot_b) - int'(st.prev_b);
		da        = (da < 0) ? -da : da;
		db        = (db < 0) ? -db : db;
		hold_ms   = HOLD_L1_MS + (int'(hold_time_level) - 1) * HOLD_STEP_MS;
		// Hold ramp spans 255 steps, each lasting a 256th of the hold time
		per_cyc   = (longint'(hold_ms) * longint'(MS_CYCLES_P)) >>> RAMP_LOG2;
		start_cur = ((hold_torque_level > PCT_MAX) ? int'(PCT_MAX) :
			int'(hold_torque_level)) * int'(max_current) / int'(PCT_MAX);
		sp        = int'(command_pot_a) - int'(FB_MID);
		mag       = (sp < 0) ? -sp : sp;
		// Gain is lowest at centre and climbs linearly to full at the ends
		centre    = NUMB_FULL - int'(numb_level) * NUMB_SPAN / 9;
		g         = centre + (((NUMB_FULL - centre) * mag) >>> 11);
		dg        = fb_high ? GAIN_BASE + int'(first_dir_limit_coarse) *
			COARSE_STEP + int'(first_dir_limit_fine) :
			GAIN_BASE + int'(second_dir_limit_coarse) * COARSE_STEP +
			int'(second_dir_limit_fine);
		fb        = int'(feedback_position_reading) - int'(FB_MID);
		deriv     = fb - int'(st.fb_prev);
		e         = ((((sp * g) >>> 6) * dg) >>> 6) - int'(st.fb_filt) -
			deriv * int'(derivative_weight);
		e         = (e > int'(max_current)) ? int'(max_current) :
			(e < -int'(max_current)) ? -int'(max_current) : e;
		// Pins pass two flops before use
		n.sync1 = {fieldbus_timeout, travel_demand, handle_released};
		n.sync2 = st.sync1;
		// ********************************************************
		// APB: read data captured in setup, write at access
		// ********************************************************
		if (psel && !penable)
		begin
			case (paddr)
				CFG_ADDR:  n.rdata = st.cfg;
				LIM_ADDR:  n.rdata = st.lim;
				CUR_ADDR:  n.rdata = st.cur;
				STAT_ADDR: n.rdata = status;
				default:   n.rdata = 32'h0;
			endcase
		end
		if (psel && penable && pwrite)
		begin
			case (paddr)
				CFG_ADDR: n.cfg = pwdata;
				LIM_ADDR: n.lim = pwdata;
				CUR_ADDR: n.cur = pwdata;
				default:  n.cfg = st.cfg;
			endcase
		end
		// ********************************************************
		// Compensation, conversion select, fieldbus gating
		// ********************************************************
		n.comp = 16'h0;
		if (comp_level != 2'h0)
			n.comp = SWITCH_DROP;
		if (comp_level == 2'h2)
			n.comp = 16'(SWITCH_DROP + 16'((32'(motor_current_meas) *
				32'(st.cfg[RES_LSB +: 8])) >> 8));
		n.fine_en   = fine_sel == 2'h1;
		n.bus_alarm = bus_present && bto;
		// ********************************************************
		// Standstill hold ramp
		// ********************************************************
		case (st.hold)
			HOLD_IDLE:
			begin
				n.hold_cur = 12'h0;
				if (rel && !trv && hold_time_level != 4'h0)
				begin
					n.hold     = HOLD_RAMP;
					n.frac     = 8'hFF;
					n.hcnt     = 32'h0;
					n.hold_cur = 12'(start_cur);
				end
			end
			HOLD_RAMP:
			begin
				n.hcnt     = st.hcnt + 32'h1;
				n.hold_cur = 12'((start_cur * int'(st.frac)) >>> RAMP_LOG2);
				if (!rel || trv)
					n.hold = HOLD_IDLE;
				else if (st.hcnt >= 32'(per_cyc - 1))
				begin
					n.hcnt = 32'h0;
					n.frac = st.frac - 8'h1;
					if (st.frac == 8'h1)
						n.hold = HOLD_DONE;
				end
			end
			HOLD_DONE:
			begin
				n.hold_cur = 12'h0;
				if (!rel || trv)
					n.hold = HOLD_IDLE;
			end
			default:
			begin
				n.hold     = HOLD_IDLE;
				n.hold_cur = 12'h0;
			end
		endcase
		// ********************************************************
		// Switch-sensed angle limits
		// ********************************************************
		n.ang  = wheel_angle;
		n.hit1 = 1'b0;
		n.hit2 = 1'b0;
		if (!closed_loop && !inhibit)
		begin
			if (fb_high && int'(wheel_angle) > lim1)
			begin
				n.ang  = 12'(lim1);
				n.hit1 = 1'b1;
			end
			else if (!fb_high && feedback_position_reading != FB_MID &&
				int'(wheel_angle) < -lim2)
			begin
				n.ang  = 12'(-lim2);
				n.hit2 = 1'b1;
			end
		end
		// ********************************************************
		// Closed-loop position update, once per millisecond
		// ********************************************************
		n.ms_cnt = tick ? 32'h0 : st.ms_cnt + 32'h1;
		if (!closed_loop)
			n.cmd = 13'sh0;
		else if (tick)
		begin
			// Level 0 follows at once; higher levels smooth harder
			n.fb_filt = 13'(int'(st.fb_filt) +
				((fb - int'(st.fb_filt)) >>> integral_weight));
			n.fb_prev = 13'(fb);
			n.cmd = 13'(e);
		end
		// Clamp each cycle too, so a lowered ceiling bites at once
		if (int'(n.cmd) > int'(max_current))
			n.cmd = 13'(max_current);
		else if (int'(n.cmd) < -int'(max_current))
			n.cmd = 13'(-int'(max_current));
		// ********************************************************
		// Set-point slope monitor
		// ********************************************************
		n.win_cnt = wtick ? 32'h0 : st.win_cnt + 32'h1;
		if (wtick)
		begin
			n.prev_a  = command_pot_a;
			n.prev_b  = command_pot_b;
			n.prev_ok = 1'b1;
			if (closed_loop && st.prev_ok &&
				(da > slope_lim || db > slope_lim))
				n.fault = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st      <= '0;
			st.cfg  <= CFG_RST;
			st.lim  <= LIM_RST;
			st.cur  <= CUR_RST;
			st.hold <= HOLD_IDLE;
		end
		else
			st <= n;
	end

	assign prdata                = st.rdata;
	assign pready                = 1'b1;
	assign pslverr               = psel && penable && !hit;
	assign motor_current_cmd     = st.cmd;
	assign hold_current          = st.hold_cur;
	assign drop_comp             = st.comp;
	assign wheel_angle_limited   = st.ang;
	assign first_limit_hit       = st.hit1;
	assign second_limit_hit      = st.hit2;
	assign fine_adc_en           = st.fine_en;
	assign fieldbus_fault_alarm  = st.bus_alarm;
	assign fieldbus_sync_en      = bus_present;
	assign setpoint_sensor_fault = st.fault;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	comp_off_a: assert property (comp_level == 2'h0 |=> drop_comp == 16'h0)
		else $error("drop offset while compensation off");
	hold_none_a: assert property (hold_time_level == 4'h0 &&
		st.hold == HOLD_IDLE |=> st.hold == HOLD_IDLE)
		else $error("hold started at level zero");
	hold_start_a: assert property (st.hold == HOLD_IDLE && rel && !trv &&
		hold_time_level != 4'h0 |=> st.hold == HOLD_RAMP &&
		st.frac == 8'hFF)
		else $error("hold ramp did not start");
	first_clamp_a: assert property (!closed_loop && !inhibit && fb_high &&
		int'(wheel_angle) > lim1 |=> first_limit_hit &&
		int'(wheel_angle_limited) == $past(lim1))
		else $error("first direction clamp wrong");
	limit_off_a: assert property (inhibit |=>
		!first_limit_hit && !second_limit_hit)
		else $error("limit active while inhibited");
	current_cap_a: assert property (int'(motor_current_cmd) <=
		int'($past(max_current)) && int'(motor_current_cmd) >=
		-int'($past(max_current)))
		else $error("current command beyond ceiling");
	bus_quiet_a: assert property (!$past(bus_present) |->
		!fieldbus_fault_alarm)
		else $error("bus alarm while bus absent");
	fine_sel_a: assert property (##1 fine_adc_en ==
		($past(fine_sel) == 2'h1))
		else $error("fine conversion select wrong");
	fault_hold_a: assert property (setpoint_sensor_fault |=>
		setpoint_sensor_fault)
		else $error("slope fault released");
	slope_dflt_a: assert property ($past(srst) |->
		st.cur[SLOPE_LSB +: 4] == LEVEL_MAX)
		else $error("slope level not 9 after reset");
endmodule : sss_top

// ### sim/sss_plant_model.sv
/*
 Far-side model: steering motor current sense, command pots, feedback
 sensor and wheel angle sensor, all sampled on the controller clock.
 Assumes the bench sets the physical quantities; the model delays them.
*/
`timescale 1ns/100ps
module sss_plant_model
(
	input  wire logic               clk,        // Controller clock
	input  wire logic [11:0]        set_pot_a,  // Bench pot a level
	input  wire logic [11:0]        set_pot_b,  // Bench pot b level
	input  wire logic [11:0]        set_fb,     // Bench feedback level
	input  wire logic signed [11:0] set_angle,  // Bench wheel angle
	input  wire logic [11:0]        set_meas,   // Bench motor current
	output logic      [11:0]        pot_a,      // Converted pot a
	output logic      [11:0]        pot_b,      // Converted pot b
	output logic      [11:0]        fb,         // Converted feedback
	output logic signed [11:0]      angle,      // Measured angle
	output logic      [11:0]        meas        // Measured current
);
	// One sample of conversion delay, as a real converter would add
	always_ff @(posedge clk)
	begin
		pot_a <= set_pot_a;
		pot_b <= set_pot_b;
		fb    <= set_fb;
		angle <= set_angle;
		meas  <= set_meas;
	end
endmodule : sss_plant_model

// ### sim/sss_top_tb_top.sv
/*
 Self-checking bench for the steering setting supervisor: APB register
 tasks, pin drives and scenario sequences with computed expectations.
 Assumes the plant model file is compiled before this one.
*/
`timescale 1ns/100ps
module sss_top_tb_top;
	import sss_pkg::*;
	localparam int MSC   = 10;
	localparam int SLC   = 40;
	localparam int LIMIT = 20000;
	logic clk, srst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr, set_pot_a, set_pot_b, set_fb, set_meas, e;
	logic [31:0] pwdata, prdata, rd;
	logic signed [11:0] set_angle, angle, wheel_angle_limited;
	logic [11:0] pot_a, pot_b, fb, meas, hold_current;
	logic handle_released, travel_demand, fieldbus_timeout;
	logic signed [12:0] motor_current_cmd;
	logic [15:0] drop_comp;
	logic first_limit_hit, second_limit_hit, fine_adc_en;
	logic fieldbus_fault_alarm, fieldbus_sync_en, setpoint_sensor_fault;
	int fail_count, checked, cycles, ci;
	int lv[4] = '{0, 1, 5, 9};

	sss_plant_model sss_plant_model_inst (.clk(clk), .set_pot_a(set_pot_a),
		.set_pot_b(set_pot_b), .set_fb(set_fb), .set_angle(set_angle),
		.set_meas(set_meas), .pot_a(pot_a), .pot_b(pot_b), .fb(fb),
		.angle(angle), .meas(meas));
	sss_top #(.MS_CYCLES_P(MSC), .SLOPE_CYCLES_P(SLC)) sss_top_inst (
		.clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.handle_released(handle_released), .travel_demand(travel_demand),
		.fieldbus_timeout(fieldbus_timeout), .command_pot_a(pot_a),
		.command_pot_b(pot_b), .feedback_position_reading(fb),
		.wheel_angle(angle), .motor_current_meas(meas),
		.motor_current_cmd(motor_current_cmd), .hold_current(hold_current),
		.drop_comp(drop_comp), .wheel_angle_limited(wheel_angle_limited),
		.first_limit_hit(first_limit_hit),
		.second_limit_hit(second_limit_hit), .fine_adc_en(fine_adc_en),
		.fieldbus_fault_alarm(fieldbus_fault_alarm),
		.fieldbus_sync_en(fieldbus_sync_en),
		.setpoint_sensor_fault(setpoint_sensor_fault));

	//****************************************
	// Tasks
	//****************************************
	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	task automatic check(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// Holds the whole request until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Samples on the falling edge so register updates have landed
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : wt

	function automatic int lim(input int l);
		return (l == 0) ? 800 : (l >= 9) ? 1180 : 840 + 38 * (l - 1);
	endfunction : lim

	//****************************************
	// Clock, timeout and sequence
	//****************************************
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			fail_count++;
			final_report();
		end
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, fieldbus_timeout} = '0;
		{fail_count, checked, cycles} = '0;
		srst = 1'b1;
		handle_released = 1'b0;
		travel_demand = 1'b1;
		set_pot_a = 12'h800;
		set_pot_b = 12'h800;
		set_fb = 12'h800;
		set_angle = 12'h000;
		set_meas = 12'h100;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		apb(0, CFG_ADDR, 0);
		check("cfg_reset", CFG_RST, rd);
		apb(0, LIM_ADDR, 0);
		check("lim_reset", LIM_RST, rd);
		apb(0, CUR_ADDR, 0);
		check("cur_reset", CUR_RST, rd);
		apb(0, STAT_ADDR, 0);
		check("status_reset", 32'h0, rd);
		apb(0, 12'h010, 0);
		check("unmapped_err", 32'(1'b1), 32'(err));
		check("unmapped_data", 32'h0, rd);
		// Level 2 with a resistance value set, as software should
		for (int l = 0; l < 3; l++)
		begin
			apb(1, CFG_ADDR, (32'(l) << COMP_LSB) | (32'h80 << RES_LSB));
			wt(3);
			e = (l == 0) ? 12'h000 : (l == 1) ? 12'h040 : 12'h0C0;
			check("drop_comp", 32'(e), 32'(drop_comp));
		end
		for (int l = 0; l < 3; l++)
		begin
			apb(1, CFG_ADDR, 32'(l) << FINE_LSB);
			wt(3);
			check("fine_adc_en", 32'(l == 1), 32'(fine_adc_en));
		end
		@(posedge clk);
		fieldbus_timeout <= 1'b1;
		for (int p = 0; p < 2; p++)
		begin
			apb(1, CFG_ADDR, 32'(p) << BUSP_BIT);
			wt(4);
			check("bus_alarm", 32'(p), 32'(fieldbus_fault_alarm));
			check("bus_sync", 32'(p), 32'(fieldbus_sync_en));
		end
		@(posedge clk);
		fieldbus_timeout <= 1'b0;
		apb(1, CFG_ADDR, 0);
		for (int i = 0; i < 4; i++)
		begin
			apb(1, LIM_ADDR, 32'(lv[i]) | (32'(lv[i] % 9) << C2_LSB));
			set_fb <= 12'h900;
			set_angle <= 12'sd1500;
			wt(4);
			e = 12'(lim(lv[i]));
			check("clamp_first", 32'(e), {20'h0, wheel_angle_limited});
			check("hit_first", 32'(1'b1), 32'(first_limit_hit));
			@(posedge clk);
			set_fb <= 12'h700;
			set_angle <= -12'sd1500;
			wt(4);
			e = 12'(-lim(lv[i] % 9));
			check("clamp_second", 32'(e), {20'h0, wheel_angle_limited});
			check("hit_second", 32'(1'b1), 32'(second_limit_hit));
		end
		apb(1, LIM_ADDR, 32'h99);
		set_fb <= 12'h900;
		set_angle <= 12'sd1500;
		wt(4);
		check("inhibit", 32'(12'sd1500), 32'(wheel_angle_limited));
		check("inhibit_hit", 32'h0, 32'(first_limit_hit));
		apb(1, LIM_ADDR, 32'h0);
		set_fb <= 12'h800;
		wt(4);
		check("mid_feedback", 32'(12'sd1500), 32'(wheel_angle_limited));
		@(posedge clk);
		set_angle <= 12'sd0;
		apb(1, CFG_ADDR, (32'h1 << HOLDT_LSB) | (32'd50 << HOLDQ_LSB));
		handle_released <= 1'b1;
		travel_demand <= 1'b0;
		wt(6);
		// Half of 4095 is 2047; the first ramp step shows 255/256 of it
		check("hold_start", 32'(2047 * 255 / 256), 32'(hold_current));
		apb(0, STAT_ADDR, 0);
		check("hold_ramp_flag", 32'(1'b1), 32'(rd[1]));
		wt(250);
		check("hold_falling", 32'(1'b1),
			32'(hold_current < 12'd2039 && hold_current != 0));
		@(posedge clk);
		travel_demand <= 1'b1;
		wt(6);
		check("hold_abort", 32'h0, 32'(hold_current));
		apb(1, CFG_ADDR, 32'h0);
		travel_demand <= 1'b0;
		wt(6);
		check("hold_level0", 32'h0, 32'(hold_current));
		// Slope level 0 is only for bench use, no twin-pot concern here
		apb(1, CUR_ADDR, 32'h0000_0FFF);
		apb(1, CFG_ADDR, 32'h1 << LOOP_BIT);
		wt(100);
		check("slope_quiet", 32'h0, 32'(setpoint_sensor_fault));
		@(posedge clk);
		set_pot_a <= 12'h800 + 12'd61;
		wt(100);
		check("slope_at_limit", 32'h0, 32'(setpoint_sensor_fault));
		@(posedge clk);
		set_pot_b <= 12'h800 + 12'd62;
		wt(100);
		check("slope_over", 32'(1'b1), 32'(setpoint_sensor_fault));
		wt(100);
		check("slope_sticky", 32'(1'b1), 32'(setpoint_sensor_fault));
		apb(0, STAT_ADDR, 0);
		check("slope_status", 32'(1'b1), 32'(rd[0]));
		// Second direction: coarse 1, fine 2, set-point 64 above mid
		apb(1, LIM_ADDR, 32'h0000_2010);
		@(posedge clk);
		set_pot_a <= 12'h840;
		wt(3 * MSC);
		check("gain_second", 32'(64 * (GAIN_BASE + COARSE_STEP + 2) / 64),
			32'(motor_current_cmd));
		apb(1, LIM_ADDR, 32'h0009_2010);
		wt(3 * MSC);
		check("numb_centre", 32'(1'b1), 32'(motor_current_cmd > 0 &&
			4 * motor_current_cmd <= GAIN_BASE + COARSE_STEP + 2));
		apb(1, CUR_ADDR, 32'h0000_0010);
		set_pot_a <= 12'hF00;
		for (int i = 0; i < 5; i++)
		begin
			wt(MSC);
			ci = motor_current_cmd;
			check("cmd_ceiling", 32'(1'b1), 32'(ci <= 16 && ci >= -16));
		end
		final_report();
	end
endmodule : sss_top_tb_top
